// ### drt_consts.vh
`ifndef DRT_CONSTS_VH
`define DRT_CONSTS_VH

// ----------------------------------------------------------------
// Register indices (byte address is four times the index)
// ----------------------------------------------------------------
`define DRT_IDX_CLK0       8'h00
`define DRT_IDX_RELOAD0    8'h02
`define DRT_IDX_COUNT0     8'h04
`define DRT_IDX_CTRL0      8'h06
`define DRT_IDX_INT0       8'h08
`define DRT_IDX_CLK1       8'h20
`define DRT_IDX_RELOAD1    8'h22
`define DRT_IDX_COUNT1     8'h24
`define DRT_IDX_CTRL1      8'h26
`define DRT_IDX_INT1       8'h28
`define DRT_IDX_STATUS     8'h30
`define DRT_IDX_MASK       8'h32
`define DRT_CH_STRIDE      8'h20

// ----------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------
`define DRT_CTRL_RUN_BIT     0
`define DRT_CTRL_PRESET_BIT  1
`define DRT_CTRL_MODE_BIT    4
`define DRT_INT_FLAG_BIT     0
`define DRT_INT_ENABLE_BIT   8

// ----------------------------------------------------------------
// Reset values and encodings
// ----------------------------------------------------------------
`define DRT_DIV_RESET      4'h0
`define DRT_DIV_RESERVED   4'hf
`define DRT_RELOAD_RESET   8'h00
`define DRT_MODE_REPEAT    1'b0
`define DRT_MODE_ONESHOT   1'b1
`define DRT_PRESCALE_W     14

`endif

// ### drt_prescaler.v
`timescale 1ns/100ps
`include "drt_consts.vh"

// Free-running divider chain shared by both channels
module drt_prescaler #(
    parameter WIDTH = `DRT_PRESCALE_W
) (
    // Clock and reset
    input  wire             clk,
    input  wire             resetn,
    // Divider chain state
    output reg  [WIDTH-1:0] preCount
);

    always @(posedge clk) begin
        if (!resetn) begin
            preCount <= {WIDTH{1'b0}};
        end else begin
            preCount <= preCount + {{(WIDTH-1){1'b0}}, 1'b1};
        end
    end

endmodule

// ### drt_channel.v
`timescale 1ns/100ps
`include "drt_consts.vh"

module drt_channel #(
    parameter CNT_W = 8,
    parameter PRE_W = `DRT_PRESCALE_W
) (
    // Clock and reset
    input  wire             clk,
    input  wire             resetn,
    // Shared divider chain
    input  wire [PRE_W-1:0] preCount,
    // Configuration
    input  wire [3:0]       divSel,
    input  wire [CNT_W-1:0] reloadVal,
    input  wire             oneShot,
    // Control strobes
    input  wire             presetPulse,
    input  wire             runSet,
    input  wire             runClear,
    // State
    output reg  [CNT_W-1:0] count_reg,
    output reg              running_reg,
    output reg              underflow_reg
);

    reg [PRE_W-1:0] tickMask;
    wire            countTick;
    integer         i;

    // Tick once every 2^divSel clocks; the reserved code never ticks
    always @* begin
        tickMask = {PRE_W{1'b0}};
        for (i = 0; i < PRE_W; i = i + 1) begin
            if (i < divSel) begin
                tickMask[i] = 1'b1; // see RULE_04
            end
        end
    end

    assign countTick = (divSel != `DRT_DIV_RESERVED) &&
                       ((preCount & tickMask) == tickMask);

    always @(posedge clk) begin
        if (!resetn) begin
            count_reg     <= {CNT_W{1'b0}};
            running_reg   <= 1'b0;
            underflow_reg <= 1'b0;
        end else begin
            underflow_reg <= 1'b0;
            if (runSet) begin
                running_reg <= 1'b1; // see RULE_12
            end else if (runClear) begin
                running_reg <= 1'b0; // see RULE_12
            end
            if (presetPulse) begin
                count_reg <= reloadVal; // see RULE_11
            end else if (running_reg && countTick) begin
                if (count_reg == {CNT_W{1'b0}}) begin
                    underflow_reg <= 1'b1; // see RULE_02
                    count_reg     <= reloadVal; // see RULE_08
                    // Self-stop loses only to a run write in the same cycle
                    if (oneShot && !runSet) begin
                        running_reg <= 1'b0; // see RULE_10
                    end
                end else begin
                    count_reg <= count_reg - {{(CNT_W-1){1'b0}}, 1'b1}; // see RULE_15
                end
            end
        end
    end

endmodule

// ### drt_timer_top.v
// Decided for this implementation: the register offsets and the APB interface to the registers.
`timescale 1ns/100ps
`include "drt_consts.vh"

// Operation
// RULE_01: Two independent channels, each with 8-bit down counter and 8-bit reload.
// RULE_02: Running channel counts down from reload and flags every underflow.
// RULE_03: Underflow feeds both the interrupt path and the serial clock output.
// RULE_04: Divider select 0x0..0xe gives 1/1..1/16384; 0xf reserved; reset 0x0.
// RULE_05: Software stops a channel before changing its divider select.
// RULE_06: Software enables the peripheral clock before running any channel.
// RULE_07: Mode bit 0 selects repeat mode, the reset default; 1 selects one-shot.
// RULE_08: Repeat mode reloads on underflow and keeps counting until stopped.
// RULE_09: Writing 1 to the mode bit gives one underflow per start.
// RULE_10: One-shot mode reloads on underflow, then clears running by itself.
// RULE_11: Writing 1 to the preset bit copies reload value into the counter.
// RULE_12: Run bit 1 starts counting; 0 stops and holds the count.
// RULE_13: Underflow sets the flag; request raised only while enable is 1.
// RULE_14: Writing 1 clears the flag; software clears it before enabling.
// RULE_15: Counter drops once per tick; underflow on the tick at 0x00.

module drt_timer_top #(
    parameter ADDR_W = 12,
    parameter CNT_W  = 8
) (
    // Clock and reset
    input  wire              clk,
    input  wire              resetn,
    // APB slave
    input  wire              psel,
    input  wire              penable,
    input  wire              pwrite,
    input  wire [ADDR_W-1:0] paddr,
    input  wire [31:0]       pwdata,
    output reg  [31:0]       prdata_reg,
    output reg               pready_reg,
    output reg               pslverr_reg,
    // Interrupt controller side
    output reg  [1:0]        irqReq_reg,
    output reg               irq_reg,
    // Serial interface transfer clocks
    output wire              serialClk0,
    output wire              serialClk1
);

    // ----------------------------------------------------------------
    // Software-visible state
    // ----------------------------------------------------------------
    reg  [3:0]       divSel_reg    [0:1];
    reg  [CNT_W-1:0] reload_reg    [0:1];
    reg  [1:0]       oneShot_reg;
    reg  [1:0]       flag_reg;
    reg  [1:0]       enable_reg;
    reg  [1:0]       flag_next;

    wire [`DRT_PRESCALE_W-1:0] preCount;
    wire [CNT_W-1:0]           countVal   [0:1];
    wire [1:0]                 running;
    wire [1:0]                 underflow;

    // ----------------------------------------------------------------
    // APB decode
    // ----------------------------------------------------------------
    wire [7:0] regIdx;
    wire       idxAligned;
    wire       setupPhase;
    wire       accessDone;
    wire       wrAccess;
    wire       chSel;
    wire [7:0] chIdx;
    reg        idxMapped;
    reg [31:0] readMux;

    assign idxAligned = (paddr[1:0] == 2'h0);
    assign regIdx     = paddr[9:2];
    assign setupPhase = psel && !penable;
    assign accessDone = psel && penable && pready_reg;
    assign wrAccess   = accessDone && pwrite && !pslverr_reg;
    // Channel 1 mirrors channel 0 one stride up
    assign chSel      = (regIdx >= `DRT_CH_STRIDE) && (regIdx < `DRT_IDX_STATUS);
    assign chIdx      = chSel ? (regIdx - `DRT_CH_STRIDE) : regIdx;

    always @* begin
        case (regIdx)
            `DRT_IDX_CLK0, `DRT_IDX_RELOAD0, `DRT_IDX_COUNT0,
            `DRT_IDX_CTRL0, `DRT_IDX_INT0,
            `DRT_IDX_CLK1, `DRT_IDX_RELOAD1, `DRT_IDX_COUNT1,
            `DRT_IDX_CTRL1, `DRT_IDX_INT1,
            `DRT_IDX_STATUS, `DRT_IDX_MASK: idxMapped = idxAligned &&
                                             (paddr[ADDR_W-1:10] == {(ADDR_W-10){1'b0}});
            default: idxMapped = 1'b0;
        endcase
    end

    // ----------------------------------------------------------------
    // Read multiplexer
    // ----------------------------------------------------------------
    always @* begin
        readMux = 32'h0000_0000;
        case (chIdx)
            `DRT_IDX_CLK0: begin
                readMux[3:0] = divSel_reg[chSel];
            end
            `DRT_IDX_RELOAD0: begin
                readMux[CNT_W-1:0] = reload_reg[chSel];
            end
            `DRT_IDX_COUNT0: begin
                readMux[CNT_W-1:0] = countVal[chSel];
            end
            `DRT_IDX_CTRL0: begin
                // Preset bit is a strobe and reads back as zero
                readMux[`DRT_CTRL_RUN_BIT]  = running[chSel];
                readMux[`DRT_CTRL_MODE_BIT] = oneShot_reg[chSel];
            end
            `DRT_IDX_INT0: begin
                readMux[`DRT_INT_FLAG_BIT]   = flag_reg[chSel];
                readMux[`DRT_INT_ENABLE_BIT] = enable_reg[chSel];
            end
            `DRT_IDX_STATUS: begin
                readMux[1:0] = flag_reg;
            end
            `DRT_IDX_MASK: begin
                readMux[1:0] = enable_reg;
            end
            default: begin
                readMux = 32'h0000_0000;
            end
        endcase
        if (!idxMapped) begin
            readMux = 32'h0000_0000;
        end
    end

    // ----------------------------------------------------------------
    // APB response: one access cycle, data captured in setup
    // ----------------------------------------------------------------
    always @(posedge clk) begin
        if (!resetn) begin
            prdata_reg  <= 32'h0000_0000;
            pready_reg  <= 1'b0;
            pslverr_reg <= 1'b0;
        end else begin
            pready_reg  <= setupPhase;
            pslverr_reg <= setupPhase && !idxMapped;
            if (setupPhase) begin
                prdata_reg <= pwrite ? 32'h0000_0000 : readMux;
            end
        end
    end

    // ----------------------------------------------------------------
    // Per-channel configuration writes
    // ----------------------------------------------------------------
    wire [1:0] wrClk;
    wire [1:0] wrReload;
    wire [1:0] wrCtrl;
    wire [1:0] wrInt;
    wire       wrStatus;
    wire       wrMask;

    assign wrStatus = wrAccess && (regIdx == `DRT_IDX_STATUS);
    assign wrMask   = wrAccess && (regIdx == `DRT_IDX_MASK);

    genvar ch;
    generate
        for (ch = 0; ch < 2; ch = ch + 1) begin : gChan
            assign wrClk[ch]    = wrAccess && (chSel == ch) && (chIdx == `DRT_IDX_CLK0);
            assign wrReload[ch] = wrAccess && (chSel == ch) && (chIdx == `DRT_IDX_RELOAD0);
            assign wrCtrl[ch]   = wrAccess && (chSel == ch) && (chIdx == `DRT_IDX_CTRL0);
            assign wrInt[ch]    = wrAccess && (chSel == ch) && (chIdx == `DRT_IDX_INT0);

            always @(posedge clk) begin
                if (!resetn) begin
                    divSel_reg[ch]  <= `DRT_DIV_RESET; // see RULE_04
                    reload_reg[ch]  <= `DRT_RELOAD_RESET;
                    oneShot_reg[ch] <= `DRT_MODE_REPEAT; // see RULE_07
                end else begin
                    // Divider change while running shifts the next tick phase
                    if (wrClk[ch]) begin
                        divSel_reg[ch] <= pwdata[3:0]; // see RULE_04
                    end
                    if (wrReload[ch]) begin
                        reload_reg[ch] <= pwdata[CNT_W-1:0];
                    end
                    if (wrCtrl[ch]) begin
                        oneShot_reg[ch] <= pwdata[`DRT_CTRL_MODE_BIT]; // see RULE_09
                    end
                end
            end

            drt_channel #(
                .CNT_W (CNT_W),
                .PRE_W (`DRT_PRESCALE_W)
            ) uChannel (
                .clk           (clk),
                .resetn        (resetn),
                .preCount      (preCount),
                .divSel        (divSel_reg[ch]),
                .reloadVal     (reload_reg[ch]),
                .oneShot       (oneShot_reg[ch]),
                .presetPulse   (wrCtrl[ch] && pwdata[`DRT_CTRL_PRESET_BIT]), // see RULE_11
                .runSet        (wrCtrl[ch] && pwdata[`DRT_CTRL_RUN_BIT]),
                .runClear      (wrCtrl[ch] && !pwdata[`DRT_CTRL_RUN_BIT]),
                .count_reg     (countVal[ch]),
                .running_reg   (running[ch]),
                .underflow_reg (underflow[ch])
            ); // see RULE_01
        end
    endgenerate

    // ----------------------------------------------------------------
    // Shared count clock divider
    // ----------------------------------------------------------------
    drt_prescaler #(
        .WIDTH (`DRT_PRESCALE_W)
    ) uPrescaler (
        .clk      (clk),
        .resetn   (resetn),
        .preCount (preCount)
    );

    // ----------------------------------------------------------------
    // Flags, enables and interrupt outputs
    // ----------------------------------------------------------------
    integer k;

    always @* begin
        flag_next = flag_reg;
        for (k = 0; k < 2; k = k + 1) begin
            if ((wrInt[k] && pwdata[`DRT_INT_FLAG_BIT]) || (wrStatus && pwdata[k])) begin
                flag_next[k] = 1'b0; // see RULE_14
            end
            // A new underflow beats a clear in the same cycle
            if (underflow[k]) begin
                flag_next[k] = 1'b1; // see RULE_13
            end
        end
    end

    always @(posedge clk) begin
        if (!resetn) begin
            flag_reg   <= 2'h0;
            enable_reg <= 2'h0;
            irqReq_reg <= 2'h0;
            irq_reg    <= 1'b0;
        end else begin
            flag_reg <= flag_next;
            if (wrInt[0]) begin
                enable_reg[0] <= pwdata[`DRT_INT_ENABLE_BIT];
            end else if (wrInt[1]) begin
                enable_reg[1] <= pwdata[`DRT_INT_ENABLE_BIT];
            end else if (wrMask) begin
                enable_reg <= pwdata[1:0];
            end
            irqReq_reg <= flag_reg & enable_reg; // see RULE_13
            irq_reg    <= |(flag_reg & enable_reg); // see RULE_03
        end
    end

    // ----------------------------------------------------------------
    // Serial transfer clocks: one-cycle underflow pulses, flop driven
    // ----------------------------------------------------------------
    assign serialClk0 = underflow[0]; // see RULE_03
    assign serialClk1 = underflow[1]; // see RULE_03

endmodule

// ### drt_timer_monitor.sv
`timescale 1ns/100ps
module drt_timer_monitor #(
    parameter ADDR_W = 12,
    parameter CNT_W  = 8
) (
    // Clock and reset
    input wire              clk,
    input wire              resetn,
    // APB
    input wire              psel,
    input wire              penable,
    input wire              pwrite,
    input wire [ADDR_W-1:0] paddr,
    input wire [31:0]       pwdata,
    input wire [31:0]       prdata_reg,
    input wire              pready_reg,
    input wire              pslverr_reg,
    // Events
    input wire [1:0]        irqReq_reg,
    input wire              irq_reg,
    input wire              serialClk0,
    input wire              serialClk1
);
    wire wrDone = psel && penable && pready_reg && pwrite;
    reg  seenWr_reg;
    // Pulses are impossible until software has written something
    always @(posedge clk) begin
        if (!resetn) begin
            seenWr_reg <= 1'b0;
        end else if (wrDone) begin
            seenWr_reg <= 1'b1;
        end
    end
    default clocking cb @(posedge clk); endclocking
    default disable iff (!resetn);
    sequence s_setup;
        psel && !penable;
    endsequence
    sequence s_access;
        psel && penable;
    endsequence
    a_ready_first: assert property (s_setup ##1 s_access |-> pready_reg)
        else $error("ready missing in first access cycle");
    a_ready_single: assert property (pready_reg |=> !pready_reg)
        else $error("ready held longer than one cycle");
    a_err_reads_zero: assert property (pslverr_reg && !pwrite |-> pready_reg && prdata_reg == 32'h0)
        else $error("refused read returned data");
    a_rdata_holds: assert property (pready_reg |=> $stable(prdata_reg))
        else $error("read data moved after access");
    a_req0_cause: assert property ($rose(irqReq_reg[0]) |-> $past(serialClk0, 2) || $past(wrDone) || $past(wrDone, 2))
        else $error("channel 0 request without cause");
    a_req1_cause: assert property ($rose(irqReq_reg[1]) |-> $past(serialClk1, 2) || $past(wrDone) || $past(wrDone, 2))
        else $error("channel 1 request without cause");
    a_irq_cause: assert property ($rose(irq_reg) |-> $past(serialClk0, 2) || $past(serialClk1, 2) || $past(wrDone, 2))
        else $error("interrupt without cause");
    a_clear_by_write: assert property ($fell(irqReq_reg[0]) || $fell(irqReq_reg[1]) || $fell(irq_reg) |-> $past(wrDone, 2))
        else $error("request dropped without a write");
    a_no_early_pulse: assert property (serialClk0 || serialClk1 |-> seenWr_reg)
        else $error("underflow pulse before any start");
endmodule

// ### drt_far_side.sv
`timescale 1ns/100ps
// Serial side stand-in: counts transfer clock pulses and channel 0 spacing
module drt_far_side (
    // Clock
    input  wire clk,
    // Transfer clocks from both channels
    input  wire serialClk0,
    input  wire serialClk1,
    // Pulse counts and last channel 0 period in clocks
    output int  pulses0,
    output int  pulses1,
    output int  gap0
);
    int age0;
    initial begin
        pulses0 = 0;
        pulses1 = 0;
        gap0 = 0;
        age0 = 0;
    end
    always @(posedge clk) begin
        age0 <= serialClk0 ? 0 : age0 + 1;
        if (serialClk0) begin
            pulses0 <= pulses0 + 1;
            gap0    <= age0 + 1;
        end
        if (serialClk1) begin
            pulses1 <= pulses1 + 1;
        end
    end
endmodule

// ### dual_reload_down_timer_tb.sv
`timescale 1ns/100ps
`include "drt_consts.vh"
module dual_reload_down_timer_tb;
    reg         clk = 1'b0;
    reg         resetn = 1'b0;
    reg         psel = 1'b0;
    reg         penable = 1'b0;
    reg         pwrite = 1'b0;
    reg  [11:0] paddr = 12'h000;
    reg  [31:0] pwdata = 32'h0;
    wire [31:0] prdata_reg;
    wire [1:0]  irqReq_reg;
    wire        pready_reg, pslverr_reg, irq_reg, serialClk0, serialClk1;
    int         err_count = 0;
    int         cmp_count = 0;
    int         pulses0, pulses1, gap0, d, p, n;
    reg  [31:0] q, h;
    reg         e;
    initial begin
        // Peripheral clock runs from time zero, before any channel starts
        forever #50 clk = ~clk;
    end
    drt_timer_top i_drt_timer_top (.clk(clk), .resetn(resetn), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata_reg(prdata_reg), .pready_reg(pready_reg), .pslverr_reg(pslverr_reg),
        .irqReq_reg(irqReq_reg), .irq_reg(irq_reg), .serialClk0(serialClk0),
        .serialClk1(serialClk1));
    drt_far_side i_drt_far_side (.clk(clk), .serialClk0(serialClk0),
        .serialClk1(serialClk1), .pulses0(pulses0), .pulses1(pulses1), .gap0(gap0));
    // ------------------------------------------------
    // Bus and compare tasks
    // ------------------------------------------------
    task automatic chk(input [31:0] got, input [31:0] exp);
        cmp_count++;
        if (got !== exp) begin
            err_count++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic apb(input w, input [7:0] idx, input [31:0] wd);
        @(posedge clk);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= w;
        paddr   <= {2'b00, idx, 2'b00};
        pwdata  <= wd;
        @(posedge clk);
        penable <= 1'b1;
        @(posedge clk);
        while (pready_reg !== 1'b1) @(posedge clk);
        q = prdata_reg;
        e = pslverr_reg;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic wr(input [7:0] idx, input [31:0] wd);
        apb(1'b1, idx, wd);
    endtask
    task automatic rd(input [7:0] idx, input [31:0] exp);
        apb(1'b0, idx, 32'h0);
        chk(q, exp);
    endtask
    task automatic tick(input int k);
        repeat (k) @(posedge clk);
    endtask
    task automatic close_out;
        $display("mismatches %0d comparisons %0d", err_count, cmp_count);
        if (err_count == 0 && cmp_count > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask
    // ------------------------------------------------
    // Tests
    // ------------------------------------------------
    initial begin
        tick(5);
        resetn <= 1'b1;
        rd(`DRT_IDX_CLK0, {28'h0, `DRT_DIV_RESET});
        rd(`DRT_IDX_RELOAD0, 32'h0);
        rd(`DRT_IDX_CTRL0, 32'h0);
        rd(`DRT_IDX_INT0, 32'h0);
        rd(`DRT_IDX_MASK, 32'h0);
        rd(8'h3f, 32'h0);
        chk({31'h0, e}, 32'h1);
        wr(`DRT_IDX_RELOAD0, 32'h1a5);
        rd(`DRT_IDX_RELOAD0, 32'ha5);
        wr(`DRT_IDX_CTRL0, 32'h2);
        wr(`DRT_IDX_COUNT0, 32'h11);
        rd(`DRT_IDX_COUNT0, 32'ha5);
        wr(`DRT_IDX_CTRL0, 32'h1);
        tick(20);
        wr(`DRT_IDX_CTRL0, 32'h0);
        apb(1'b0, `DRT_IDX_COUNT0, 32'h0);
        h = q;
        chk({31'h0, h != 32'ha5}, 32'h1);
        tick(30);
        rd(`DRT_IDX_COUNT0, h);
        // Every ratio up to 1/128, then the slowest one
        for (d = 0; d < 15; d = (d == 7) ? 14 : d + 1) begin
            wr(`DRT_IDX_CTRL0, 32'h0);
            wr(`DRT_IDX_CLK0, d);
            wr(`DRT_IDX_RELOAD0, (d == 14) ? 0 : 3);
            p = pulses0;
            wr(`DRT_IDX_CTRL0, 32'h3);
            n = 0;
            while (pulses0 < p + 2 && n < 40000) begin
                @(posedge clk);
                n++;
            end
            chk(gap0, ((d == 14) ? 1 : 4) << d);
        end
        wr(`DRT_IDX_CTRL0, 32'h0);
        wr(`DRT_IDX_CLK0, `DRT_DIV_RESERVED);
        p = pulses0;
        wr(`DRT_IDX_CTRL0, 32'h3);
        tick(100);
        chk(pulses0 - p, 0);
        wr(`DRT_IDX_CTRL0, 32'h0);
        wr(`DRT_IDX_CLK0, 32'h0);
        wr(`DRT_IDX_RELOAD0, 32'h5);
        wr(`DRT_IDX_INT0, 32'h1);
        p = pulses0;
        wr(`DRT_IDX_CTRL0, 32'h13);
        tick(40);
        chk(pulses0 - p, 1);
        rd(`DRT_IDX_CTRL0, 32'h10);
        rd(`DRT_IDX_COUNT0, 32'h5);
        rd(`DRT_IDX_INT0, 32'h1);
        rd(`DRT_IDX_STATUS, 32'h1);
        chk({29'h0, irq_reg, irqReq_reg}, 32'h0);
        wr(`DRT_IDX_INT0, 32'h100);
        tick(2);
        chk({29'h0, irq_reg, irqReq_reg}, 32'h5);
        wr(`DRT_IDX_MASK, 32'h1);
        tick(2);
        chk({31'h0, irq_reg}, 32'h1);
        wr(`DRT_IDX_MASK, 32'h0);
        tick(2);
        chk({31'h0, irq_reg}, 32'h0);
        wr(`DRT_IDX_MASK, 32'h1);
        wr(`DRT_IDX_STATUS, 32'h1);
        tick(2);
        chk({29'h0, irq_reg, irqReq_reg}, 32'h0);
        rd(`DRT_IDX_INT0, 32'h100);
        // Channel 1 runs alone and reaches the interrupt path
        wr(`DRT_IDX_CLK1, 32'h1);
        wr(`DRT_IDX_RELOAD1, 32'h2);
        wr(`DRT_IDX_INT1, 32'h100);
        p = pulses0;
        h = pulses1;
        wr(`DRT_IDX_CTRL1, 32'h3);
        tick(30);
        chk(pulses0 - p, 0);
        chk({31'h0, pulses1 - h >= 3}, 32'h1);
        chk({30'h0, irqReq_reg}, 32'h2);
        wr(`DRT_IDX_MASK, 32'h2);
        tick(2);
        chk({31'h0, irq_reg}, 32'h1);
        wr(`DRT_IDX_CTRL1, 32'h0);
        wr(`DRT_IDX_STATUS, 32'h2);
        tick(2);
        chk({29'h0, irq_reg, irqReq_reg}, 32'h0);
        close_out;
    end
    initial begin
        repeat (60000) @(posedge clk);
        err_count++;
        $display("mismatch at %0t: run did not finish", $time);
        close_out;
    end
endmodule
bind drt_timer_top drt_timer_monitor #(.ADDR_W(ADDR_W), .CNT_W(CNT_W)) i_drt_timer_monitor (
    .clk(clk), .resetn(resetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata_reg(prdata_reg), .pready_reg(pready_reg),
    .pslverr_reg(pslverr_reg), .irqReq_reg(irqReq_reg), .irq_reg(irq_reg),
    .serialClk0(serialClk0), .serialClk1(serialClk1));
